// File: hw/timer8_pwm_map.vh
// register map, field positions, reset values and timing counts of the 8-bit pwm timer
// assumes it is included by bare name from the design file; definitions only
`ifndef TIMER8_PWM_MAP_VH
`define TIMER8_PWM_MAP_VH

// byte addresses of the register words
`define REG_CTRL_ADDR 5'h00
`define REG_COUNT_ADDR 5'h04
`define REG_COMPARE_ADDR 5'h08
`define REG_STATUS_ADDR 5'h0c
`define REG_PORT_ADDR 5'h10

// control word fields
`define CTRL_MODE_LSB 0
`define CTRL_ACTION_LSB 2
`define CTRL_CLKSEL_LSB 4
`define CTRL_RESET 8'h00

// status word fields, wrap and match flags clear on write of one
`define STAT_WRAP_BIT 0
`define STAT_MATCH_BIT 1
`define STAT_DIR_BIT 2
`define STAT_WAVE_BIT 3

// port word fields
`define PORT_DIR_BIT 0
`define PORT_DATA_BIT 1

// waveform modes
`define MODE_NORMAL 2'h0
`define MODE_PHASE 2'h1
`define MODE_CTC 2'h2
`define MODE_FAST 2'h3

// output actions
`define ACT_OFF 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_NONINV 2'h2
`define ACT_INV 2'h3

// counter limits
`define CNT_BOTTOM 8'h00
`define CNT_MAX 8'hff
`define CNT_RESET 8'h00
`define COMPARE_RESET 8'h00

// prescaler taps: divide by 8, 64, 256, 1024 means all ones in the low bits
`define PRE_DIV8_MASK 10'h007
`define PRE_DIV64_MASK 10'h03f
`define PRE_DIV256_MASK 10'h0ff
`define PRE_DIV1024_MASK 10'h3ff

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hw/timer8_pwm_waveform_gen.v
// 8-bit timer with fast pwm and phase correct pwm waveform generation, axi4-lite registers
// assumes one clock aclk, synchronous active-low reset, inputs synchronous to aclk
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_pwm_map.vh"

module timer8_pwm_waveform_gen (
    input wire aclk,
    input wire aresetn,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg wave_pin_o,
    output reg wave_pin_oe
);

    // decode of the clock select into a tick enable from the prescaler
    function tick_from_sel;
        input [2:0] sel;
        input [9:0] pre;
        begin
            case (sel)
                // no prescaling, tick every clock
                3'h1: tick_from_sel = 1'b1;
                3'h2: tick_from_sel = ((pre & `PRE_DIV8_MASK) == `PRE_DIV8_MASK);
                3'h3: tick_from_sel = ((pre & `PRE_DIV64_MASK) == `PRE_DIV64_MASK);
                3'h4: tick_from_sel = ((pre & `PRE_DIV256_MASK) == `PRE_DIV256_MASK);
                3'h5: tick_from_sel = ((pre & `PRE_DIV1024_MASK) == `PRE_DIV1024_MASK);
                // stopped, external sources have no pin here
                default: tick_from_sel = 1'b0;
            endcase
        end
    endfunction

    // address decode: is the word address one of ours
    function addr_ok;
        input [4:0] a;
        begin
            addr_ok = (a[1:0] == 2'h0) && (a <= `REG_PORT_ADDR);
        end
    endfunction

    // control and state registers
    reg [1:0] mode_q; // waveform_mode_sel
    reg [1:0] action_q; // out_action_sel
    reg [2:0] clk_sel_q; // prescale choice
    reg [9:0] pre_q; // free running prescaler
    reg [7:0] count_q; // count_value
    reg [7:0] count_d;
    reg up_q; // counting direction, 1 = up
    reg up_d;
    reg [7:0] compare_buf_q; // software written compare_value
    reg [7:0] compare_q; // compare value used for matching
    reg wave_q; // wave_out register
    reg wave_d;
    reg wrap_flag_q; // sticky wrap_flag
    reg match_flag_q; // sticky match_flag
    reg block_q; // suppresses match on tick after count write
    reg pin_dir_q; // pin direction, 1 = output
    reg port_data_q; // normal port output level

    // bus write channel state
    reg aw_held_q; // write address captured
    reg w_held_q; // write data captured
    reg [4:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    wire tick_enable; // prescaled timer tick, used as enable only
    wire do_write; // both halves of a write are present
    wire wr_lane0; // low byte enabled
    wire hit; // count equals the active compare value
    wire match; // hit that is honoured this tick
    wire at_max; // count at max
    wire at_bottom; // count at bottom
    wire top_special; // compare at top with high action bit
    wire [7:0] cnt_inc; // count plus one
    wire [7:0] cnt_dec; // count minus one
    wire wr_count; // software writes the count this cycle
    wire wr_status; // software writes status this cycle
    reg wrap_set; // hardware event for wrap flag
    reg compare_load; // copy buffered compare into active one

    assign tick_enable = tick_from_sel(clk_sel_q, pre_q);
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_lane0 = w_strb_q[0];
    assign wr_count = do_write && wr_lane0 && (aw_addr_q == `REG_COUNT_ADDR);
    assign wr_status = do_write && wr_lane0 && (aw_addr_q == `REG_STATUS_ADDR);
    assign at_max = (count_q == `CNT_MAX);
    assign at_bottom = (count_q == `CNT_BOTTOM);
    assign hit = (count_q == compare_q);
    assign cnt_inc = count_q + 8'h01;
    assign cnt_dec = count_q - 8'h01;
    assign top_special = action_q[1] && (compare_q == `CNT_MAX) &&
                         ((mode_q == `MODE_FAST) || (mode_q == `MODE_PHASE));
    assign match = tick_enable && hit && !block_q && !top_special;

    // prescaler runs freely so ticks stay evenly spaced
    always @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= 10'h000;
        end else begin
            pre_q <= pre_q + 10'h001;
        end
    end

    // next count, direction, output level and events
    always @* begin
        count_d = count_q;
        up_d = up_q;
        wave_d = wave_q;
        wrap_set = 1'b0;
        compare_load = 1'b0;
        if (tick_enable) begin
            case (mode_q)
                `MODE_FAST: begin
                    if (at_max) begin
                        count_d = `CNT_BOTTOM;
                        wrap_set = 1'b1;
                        compare_load = 1'b1;
                    end else begin
                        count_d = cnt_inc;
                    end
                    if (action_q == `ACT_TOGGLE) begin
                        if (match) begin
                            wave_d = ~wave_q;
                        end
                    end else if (action_q[1]) begin
                        // spike or constant, falls out of match then wrap order
                        if (at_max) begin
                            // set at wrap, clear at wrap
                            wave_d = ~action_q[0];
                        end else if (match) begin
                            // clear on match, set on match
                            wave_d = action_q[0];
                        end
                    end
                end
                `MODE_PHASE: begin
                    // dual slope, max held one tick, period 510
                    if (up_q) begin
                        if (at_max) begin
                            count_d = cnt_dec;
                            up_d = 1'b0;
                            compare_load = 1'b1;
                        end else begin
                            count_d = cnt_inc;
                        end
                    end else begin
                        if (at_bottom) begin
                            count_d = cnt_inc;
                            up_d = 1'b1;
                        end else begin
                            count_d = cnt_dec;
                        end
                    end
                    if (at_bottom) begin
                        wrap_set = 1'b1;
                    end
                    if (action_q[1]) begin
                        if (at_max) begin
                            // level at max from up match, missed match, at top
                            wave_d = top_special ? ~action_q[0] : action_q[0];
                        end else if (match) begin
                            // up clears, down sets; bottom counts as up
                            wave_d = (up_q || at_bottom) ? action_q[0] : ~action_q[0];
                        end
                    end
                end
                `MODE_CTC: begin
                    // compare value is the top
                    count_d = hit ? `CNT_BOTTOM : cnt_inc;
                    wrap_set = at_max;
                    if (match) begin
                        wave_d = (action_q == `ACT_TOGGLE) ? ~wave_q :
                                 (action_q == `ACT_OFF) ? wave_q : action_q[0];
                    end
                end
                default: begin
                    // normal mode, plain wrap
                    count_d = cnt_inc;
                    wrap_set = at_max;
                    if (match) begin
                        wave_d = (action_q == `ACT_TOGGLE) ? ~wave_q :
                                 (action_q == `ACT_OFF) ? wave_q : action_q[0];
                    end
                end
            endcase
        end
        if (wr_count) begin
            // software write overrides the counter
            count_d = w_data_q[7:0];
        end
    end

    // counter, direction, output and compare registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= `CNT_RESET;
            up_q <= 1'b1;
            wave_q <= 1'b0;
            compare_q <= `COMPARE_RESET;
            block_q <= 1'b0;
        end else begin
            count_q <= count_d;
            up_q <= up_d;
            wave_q <= wave_d;
            // match blocked on the tick after a count write
            if (wr_count) begin
                block_q <= 1'b1;
            end else if (tick_enable) begin
                block_q <= 1'b0;
            end
            // immediate in non-pwm modes, buffered in pwm modes
            if (!mode_q[0] || compare_load) begin
                compare_q <= compare_buf_q;
            end
        end
    end

    // sticky flags: a hardware set wins over a clear in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            wrap_flag_q <= 1'b0;
            match_flag_q <= 1'b0;
        end else begin
            if (wrap_set) begin
                wrap_flag_q <= 1'b1;
            end else if (wr_status && w_data_q[`STAT_WRAP_BIT]) begin
                wrap_flag_q <= 1'b0;
            end
            if (match) begin
                match_flag_q <= 1'b1;
            end else if (wr_status && w_data_q[`STAT_MATCH_BIT]) begin
                match_flag_q <= 1'b0;
            end
        end
    end

    // pin drive: waveform overrides the port when an action is chosen
    always @(posedge aclk) begin
        if (!aresetn) begin
            wave_pin_o <= 1'b0;
            wave_pin_oe <= 1'b0;
        end else begin
            // action zero gives port, direction gates driver
            wave_pin_o <= (action_q == `ACT_OFF) ? port_data_q : wave_d;
            wave_pin_oe <= pin_dir_q;
        end
    end

    // configuration registers written by software
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= 2'h0;
            action_q <= 2'h0;
            clk_sel_q <= 3'h0;
            compare_buf_q <= `COMPARE_RESET;
            pin_dir_q <= 1'b0;
            port_data_q <= 1'b0;
        end else if (do_write && wr_lane0) begin
            case (aw_addr_q)
                `REG_CTRL_ADDR: begin
                    mode_q <= w_data_q[`CTRL_MODE_LSB +: 2];
                    action_q <= w_data_q[`CTRL_ACTION_LSB +: 2];
                    clk_sel_q <= w_data_q[`CTRL_CLKSEL_LSB +: 3];
                end
                `REG_COMPARE_ADDR: begin
                    compare_buf_q <= w_data_q[7:0];
                end
                `REG_PORT_ADDR: begin
                    pin_dir_q <= w_data_q[`PORT_DIR_BIT];
                    port_data_q <= w_data_q[`PORT_DATA_BIT];
                end
                // other words carry no configuration
                default: begin
                end
            endcase
        end
    end

    // write channel: address and data taken in either order, answer after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 5'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            // ready is a one-cycle pulse taking the offered item
            s_axi_awready <= s_axi_awvalid && !aw_held_q && !s_axi_awready;
            s_axi_wready <= s_axi_wvalid && !w_held_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                // write is applied now, answer follows
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one read at a time, data sampled when the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                case (s_axi_araddr)
                    `REG_CTRL_ADDR: s_axi_rdata <= {25'h0000000, clk_sel_q, action_q, mode_q};
                    `REG_COUNT_ADDR: s_axi_rdata <= {24'h000000, count_q};
                    `REG_COMPARE_ADDR: s_axi_rdata <= {24'h000000, compare_buf_q};
                    `REG_STATUS_ADDR: s_axi_rdata <= {28'h0000000, wave_q, up_q, match_flag_q, wrap_flag_q};
                    `REG_PORT_ADDR: s_axi_rdata <= {30'h00000000, port_data_q, pin_dir_q};
                    // unmapped word reads zero with an error answer
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // timer8_pwm_waveform_gen

`default_nettype wire

// File: tb/pwm_load.sv
// load model on the waveform pin: resolves the pad and counts high cycles
// assumes one clock; the load pulls the pad down when the pin is not driven
`timescale 1ns/1ps
`default_nettype none
module pwm_load (
    input wire logic aclk,
    input wire logic clr,
    input wire logic wave_pin_o,
    input wire logic wave_pin_oe,
    output wire logic pad,
    output var int hi_cnt
);
    assign pad = wave_pin_oe ? wave_pin_o : 1'b0;
    // high-cycle counter on the resolved pad, clr restarts the window
    always @(posedge aclk) begin
        if (clr)
            hi_cnt <= 0;
        else if (pad === 1'b1)
            hi_cnt <= hi_cnt + 1;
    end
endmodule // pwm_load
`default_nettype wire

// File: tb/testbench.sv
// bench for the pwm timer: axi4-lite master tasks, duty checks by high-cycle counts over two periods
// assumes the load model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, clr;
    logic [4:0] awaddr, araddr;
    logic [3:0] wstrb;
    logic [31:0] wdata;
    wire awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, pad;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int errors, checks, hi;
    timer8_pwm_waveform_gen i_timer8_pwm_waveform_gen (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wave_pin_o(pin_o), .wave_pin_oe(pin_oe));
    pwm_load i_pwm_load (.aclk(aclk), .clr(clr), .wave_pin_o(pin_o), .wave_pin_oe(pin_oe),
        .pad(pad), .hi_cnt(hi));
    // 20 MHz clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic stuck;
        errors++;
        $display("[FAIL] handshake expected answer seen timeout");
        report_and_stop;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bus write: address and data offered together, each released when taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1)
                awvalid <= 1'b0;
            if (wvalid && wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                @(posedge aclk);
                return;
            end
        end
        stuck;
    endtask
    // bus read: request held until taken, rready held until the answer
    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                @(posedge aclk);
                return;
            end
        end
        stuck;
    endtask
    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, e, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask
    // stop, load compare and count, then start with the given control byte
    task automatic cfg(input logic [7:0] ctl, input logic [7:0] c);
        logic [1:0] r;
        wr(5'h00, 32'h0, r);
        wr(5'h08, {24'h0, c}, r);
        wr(5'h04, 32'h0, r);
        wr(5'h00, {24'h0, ctl}, r);
    endtask
    // settle one period, then count high cycles over two periods
    task automatic pwm(input string nm, input logic [7:0] ctl, input logic [7:0] c, input int per, input int e);
        cfg(ctl, c);
        repeat (per) @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (2 * per) @(posedge aclk);
        @(posedge aclk);
        chk(nm, e, hi);
    endtask
    task automatic t_reset;
        chk("pin", 32'h0, {31'h0, pin_o});
        rchk("ctrl", 5'h00, 32'h0, 2'h0);
        rchk("count", 5'h04, 32'h0, 2'h0);
        rchk("compare", 5'h08, 32'h0, 2'h0);
        rchk("status", 5'h0c, 32'h4, 2'h0);
        $display("test reset done");
    endtask
    task automatic t_regs;
        logic [1:0] r;
        wr(5'h04, 32'h55, r);
        rchk("count", 5'h04, 32'h55, 2'h0);
        wr(5'h08, 32'ha5, r);
        rchk("compare", 5'h08, 32'ha5, 2'h0);
        rchk("unmapped", 5'h02, 32'h0, 2'h2);
        wr(5'h06, 32'h1, r);
        chk("bresp", 32'h2, {30'h0, r});
        // port data high while the pin is an input: the load holds the pad low
        wr(5'h10, 32'h2, r);
        chk("pad input", 32'h0, {31'h0, pad});
        wr(5'h10, 32'h3, r);
        chk("bresp port", 32'h0, {30'h0, r});
        chk("pad output", 32'h1, {31'h0, pad});
        rchk("port", 5'h10, 32'h3, 2'h0);
        $display("test regs done");
    endtask
    task automatic t_fast;
        pwm("fast noninv", 8'h1b, 8'h40, 256, 130);
        pwm("fast inv", 8'h1f, 8'h40, 256, 382);
        pwm("fast spike", 8'h1b, 8'h00, 256, 2);
        pwm("fast max", 8'h1b, 8'hff, 256, 512);
        pwm("fast inv max", 8'h1f, 8'hff, 256, 0);
        pwm("fast toggle", 8'h17, 8'h00, 256, 256);
        pwm("fast off", 8'h13, 8'h40, 256, 512);
        $display("test fast done");
    endtask
    task automatic t_phase;
        pwm("phase noninv", 8'h19, 8'h40, 510, 256);
        pwm("phase inv", 8'h1d, 8'h40, 510, 764);
        pwm("phase low", 8'h19, 8'h00, 510, 0);
        pwm("phase high", 8'h19, 8'hff, 510, 1020);
        pwm("phase inv low", 8'h1d, 8'h00, 510, 1020);
        $display("test phase done");
    endtask
    task automatic t_presc;
        pwm("fast div8", 8'h2b, 8'h40, 2048, 1040);
        pwm("fast div64", 8'h3b, 8'h40, 16384, 8320);
        pwm("phase div8", 8'h29, 8'h40, 4080, 2048);
        $display("test prescale done");
    endtask
    // wrap flag sets while running, clears by writing one when stopped
    task automatic t_flags;
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] ctl [2] = '{8'h1b, 8'h19};
        foreach (ctl[i]) begin
            cfg(ctl[i], 8'h40);
            repeat (600) @(posedge aclk);
            rd(5'h0c, d, r);
            chk("wrap set", 32'h1, {31'h0, d[0]});
            chk("match set", 32'h1, {31'h0, d[1]});
            wr(5'h00, 32'h0, r);
            wr(5'h0c, 32'h3, r);
            chk("bresp status", 32'h0, {30'h0, r});
            rd(5'h0c, d, r);
            chk("wrap clear", 32'h0, {31'h0, d[0]});
            chk("match clear", 32'h0, {31'h0, d[1]});
        end
        $display("test flags done");
    endtask
    initial begin
        errors = 0;
        checks = 0;
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        clr = 1'b0;
        awaddr = 5'h00;
        araddr = 5'h00;
        wstrb = 4'h0;
        wdata = 32'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_regs;
        t_fast;
        t_phase;
        t_presc;
        t_flags;
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire

// File: tb/timer8_pwm_chk_assertions.sv
// checker for the pwm timer: bus handshakes and waveform reset level
// assumes bind to timer8_pwm_waveform_gen, one clock aclk, sync reset aresetn
`timescale 1ns/1ps
`default_nettype none
module timer8_pwm_chk (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire wave_pin_o,
    input wire wave_pin_oe
);
    // one domain: shared clock and reset for all checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RST_LOW: assert property ($rose(aresetn) |-> !wave_pin_o && !wave_pin_oe)
        else $error("pin not low after reset");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready longer than one cycle");
    AST_AR_CAUSE: assert property (s_axi_arready |-> s_axi_arvalid)
        else $error("read ready without request");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write answer late");
    AST_RESP: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
        else $error("write response code illegal");
    AST_W_PAIR: assert property (s_axi_wready |-> s_axi_wvalid ##1 !s_axi_wready)
        else $error("data ready without data");
endmodule // timer8_pwm_chk
bind timer8_pwm_waveform_gen timer8_pwm_chk i_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wave_pin_o(wave_pin_o), .wave_pin_oe(wave_pin_oe));
`default_nettype wire
